/* File: logic/meiu_pkg.sv */
// constants for the motion event interrupt unit
package meiu_pkg;
    localparam int NUM_SRC = 32;
    localparam int NUM_CMP = 8;
    localparam int POS_W = 32;
    localparam int LINE_W = 16;
    // register offsets (word index == byte address / 4)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_SETUP = 8'h08;
    localparam logic [7:0] REG_ACTIVE = 8'h0C;
    localparam logic [7:0] REG_RETURN = 8'h10;
    localparam logic [7:0] REG_HWEN = 8'h14;
    localparam logic [7:0] REG_DRIVE = 8'h18;
    localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
    localparam logic [7:0] REG_IRQ_CLR = 8'h20;
    localparam logic [7:0] REG_IRQ_EN = 8'h24;
    localparam logic [7:0] REG_CMP_SEL = 8'h28;
    localparam logic [7:0] REG_CMP_ON = 8'h2C;
    localparam logic [7:0] REG_CMP_OFF = 8'h30;
    localparam logic [7:0] REG_VECTOR = 8'h34;
    // control word and drive word bits
    localparam int CTRL_GDIS = 0;
    localparam int CTRL_GEN = 1;
    localparam int DRV_EN = 0;
    localparam int DRV_DIS = 1;
    localparam int DRV_CLRF = 2;
    // setup word fields
    localparam int SETUP_SRC_LSB = 0;
    localparam int SETUP_EDGE_LSB = 8;
    localparam int SETUP_LINE_LSB = 16;
    // edge codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // comparator sources and hardware enable select
    localparam logic [1:0] CMP_SRC_FB = 2'h0;
    localparam logic [1:0] CMP_SRC_MASTER = 2'h1;
    localparam logic [1:0] CMP_SRC_CAM = 2'h2;
    localparam int HWEN_W = 13;
    localparam int HWEN_UNUSABLE = 8;
    localparam logic [12:0] HWEN_RST = 13'h0000;
    // interrupt status bits
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_RETI = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_W = 3;
endpackage

/* File: logic/position_window_cmp.sv */
// one position window comparator
`timescale 1ns/100ps
module position_window_cmp
    import meiu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] src_sel_i,
    input wire logic [POS_W-1:0] first_pos_i,
    input wire logic [POS_W-1:0] last_pos_i,
    input wire logic [POS_W-1:0] axis_feedback_position_i,
    input wire logic [POS_W-1:0] master_position_i,
    input wire logic [POS_W-1:0] cam_master_position_i,
    output logic in_window_o
);
    logic [POS_W-1:0] quantity;

    // quantity chosen by source code; code 3 compares against zero
    always_comb begin
        case (src_sel_i)
            CMP_SRC_FB: quantity = axis_feedback_position_i; // [R08]
            CMP_SRC_MASTER: quantity = master_position_i; // [R08]
            CMP_SRC_CAM: quantity = cam_master_position_i; // [R08]
            default: quantity = '0;
        endcase
    end

    // signed window test, registered so the flag is glitch free
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_window_o <= 1'b0;
        end else begin
            in_window_o <= ($signed(quantity) >= $signed(first_pos_i)) &&
                ($signed(quantity) <= $signed(last_pos_i)); // [R09]
        end
    end
endmodule // position_window_cmp

/* File: logic/motion_event_interrupt_unit.sv */
// event sources, interrupt vectoring, comparators and drive enable
// Contract
// [R01] read-only 32-bit event word, fixed bit layout
// [R02] armed edge: interrupt, disarm source, branch
// [R03] global interrupt disable and enable commands
// [R04] two-bit edge: off, rise, fall, both
// [R05] setup stores handler line and edge
// [R06] readable number of serviced source
// [R07] return resumes program and re-enables interrupts
// [R08] comparator source: feedback, master, cam master
// [R09] eight window comparators with first/last position
// [R10] hardware enable select; bit 8 unusable
// [R11] zero select: software drive enable/disable
// [R12] command clears latched drive fault
// [R13] sample sources each clock, edge by compare
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module motion_event_interrupt_unit
    import meiu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [7:0] local_inputs_i,
    input wire logic [4:0] motion_flags_i,
    input wire logic [3:0] drive_status_word_i,
    input wire logic timer_event_i,
    input wire logic cam_index_i,
    input wire logic bus_message_i,
    input wire logic [1:0] input_capture_i,
    input wire logic [3:0] drive_inputs_i,
    input wire logic drive_fault_i,
    input wire logic [POS_W-1:0] axis_feedback_position_i,
    input wire logic [POS_W-1:0] master_position_i,
    input wire logic [POS_W-1:0] cam_master_position_i,
    input wire logic handler_done_i,
    output logic interrupt_req_o,
    output logic [LINE_W-1:0] handler_line_o,
    output logic [4:0] active_source_number_o,
    output logic drive_enable_o,
    output logic drive_fault_o,
    output logic irq_o
);
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HANDLER = 2'b10
    } exec_state_t;

    logic [7:0] loc_s1, loc_s2;
    logic [4:0] mf_s1, mf_s2;
    logic [3:0] ds_s1, ds_s2;
    logic [2:0] misc_s1, misc_s2;
    logic [1:0] cap_s1, cap_s2;
    logic [3:0] din_s1, din_s2;
    logic flt_s1, flt_s2;
    logic [NUM_CMP-1:0] comparator_flags;
    logic [NUM_SRC-1:0] event_source_status;
    logic [NUM_SRC-1:0] prev_status;
    logic [NUM_SRC-1:0] hit;
    logic [1:0] edge_sel [NUM_SRC];
    logic [LINE_W-1:0] vector_line [NUM_SRC];
    logic [1:0] cmp_src [NUM_CMP];
    logic [POS_W-1:0] cmp_on [NUM_CMP];
    logic [POS_W-1:0] cmp_off [NUM_CMP];
    logic [2:0] cmp_index;
    logic global_en;
    exec_state_t state;
    logic [4:0] next_src;
    logic next_found;
    logic [HWEN_W-1:0] hardware_enable_select;
    logic sw_drive_en;
    logic fault_latched;
    logic [IRQ_W-1:0] irq_stat, irq_en, irq_evt;
    logic take_irq, do_reti;
    logic [4:0] setup_src;

    // returns true when a write strobe hits the given offset
    function automatic logic wr_hit(input logic [7:0] off);
        return wr_i && (addr_i == off);
    endfunction

    // two-flop synchronisers for the event source, drive input and fault pins; handler_done_i and positions are used directly
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loc_s1 <= '0; loc_s2 <= '0;
            mf_s1 <= '0; mf_s2 <= '0;
            ds_s1 <= '0; ds_s2 <= '0;
            misc_s1 <= '0; misc_s2 <= '0;
            cap_s1 <= '0; cap_s2 <= '0;
            din_s1 <= '0; din_s2 <= '0;
            flt_s1 <= 1'b0; flt_s2 <= 1'b0;
        end else begin
            loc_s1 <= local_inputs_i; loc_s2 <= loc_s1;
            mf_s1 <= motion_flags_i; mf_s2 <= mf_s1;
            ds_s1 <= drive_status_word_i; ds_s2 <= ds_s1;
            misc_s1 <= {bus_message_i, cam_index_i, timer_event_i};
            misc_s2 <= misc_s1;
            cap_s1 <= input_capture_i; cap_s2 <= cap_s1;
            din_s1 <= drive_inputs_i; din_s2 <= din_s1;
            flt_s1 <= drive_fault_i; flt_s2 <= flt_s1;
        end
    end

    // eight window comparators, each with its own source and window
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            position_window_cmp u_cmp (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .src_sel_i(cmp_src[gi]),
                .first_pos_i(cmp_on[gi]),
                .last_pos_i(cmp_off[gi]),
                .axis_feedback_position_i(axis_feedback_position_i),
                .master_position_i(master_position_i),
                .cam_master_position_i(cam_master_position_i),
                .in_window_o(comparator_flags[gi]) // [R09]
            );
        end
    endgenerate

    // live event word; reserved bits 20-21 read zero
    assign event_source_status = {cap_s2, comparator_flags, 2'b00,
        misc_s2, ds_s2, mf_s2, loc_s2}; // [R01] [R13]

    // previous sample, so each edge is seen once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_status <= '0;
        end else begin
            prev_status <= event_source_status; // [R13]
        end
    end

    // edge qualification per source
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_edge
            always_comb begin
                case (edge_sel[gi])
                    EDGE_RISE: hit[gi] = event_source_status[gi] &
                        ~prev_status[gi]; // [R04]
                    EDGE_FALL: hit[gi] = ~event_source_status[gi] &
                        prev_status[gi]; // [R04]
                    EDGE_BOTH: hit[gi] = event_source_status[gi] ^
                        prev_status[gi]; // [R04]
                    default: hit[gi] = 1'b0; // [R04]
                endcase
            end
        end
    endgenerate

    // lowest numbered hit wins when several arrive together
    always_comb begin
        next_src = '0;
        next_found = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (hit[i]) begin
                next_src = 5'(i);
                next_found = 1'b1;
            end
        end
    end

    assign take_irq = (state == ST_RUN) && global_en && next_found;
    assign do_reti = (state == ST_HANDLER) &&
        (wr_hit(REG_RETURN) || handler_done_i);
    assign setup_src = wdata_i[SETUP_SRC_LSB +: 5];

    // edge table and handler lines; a taken source is disarmed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                edge_sel[i] <= EDGE_OFF;
                vector_line[i] <= '0;
            end
        end else begin
            if (wr_hit(REG_SETUP)) begin
                edge_sel[setup_src] <= wdata_i[SETUP_EDGE_LSB +: 2]; // [R05]
                vector_line[setup_src] <=
                    wdata_i[SETUP_LINE_LSB +: LINE_W]; // [R05]
            end
            // disarm after setup so the taken source always ends off
            if (take_irq) begin
                edge_sel[next_src] <= EDGE_OFF; // [R02]
            end
        end
    end

    // global gate: commands, cleared on entry, restored by return
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            global_en <= 1'b0;
        end else if (take_irq) begin
            global_en <= 1'b0; // [R02]
        end else if (do_reti) begin
            global_en <= 1'b1; // [R07]
        end else if (wr_hit(REG_CTRL) && wdata_i[CTRL_GDIS]) begin
            global_en <= 1'b0; // [R03]
        end else if (wr_hit(REG_CTRL) && wdata_i[CTRL_GEN]) begin
            global_en <= 1'b1; // [R03]
        end
    end

    // execution state: run, or suspended in a handler
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_RUN;
            active_source_number_o <= '0;
            handler_line_o <= '0;
            interrupt_req_o <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (take_irq) begin
                        state <= ST_HANDLER;
                        active_source_number_o <= next_src; // [R06]
                        handler_line_o <= vector_line[next_src]; // [R02]
                        interrupt_req_o <= 1'b1; // [R02]
                    end
                end
                ST_HANDLER: begin
                    if (do_reti) begin
                        state <= ST_RUN; // [R07]
                        interrupt_req_o <= 1'b0; // [R07]
                    end
                end
                default: begin
                    state <= ST_RUN;
                    interrupt_req_o <= 1'b0;
                end
            endcase
        end
    end

    // comparator programming: select word chooses comparator
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_index <= '0;
            for (int i = 0; i < NUM_CMP; i++) begin
                cmp_src[i] <= CMP_SRC_FB;
                cmp_on[i] <= '0;
                cmp_off[i] <= '0;
            end
        end else begin
            if (wr_hit(REG_CMP_SEL)) begin
                cmp_index <= wdata_i[2:0]; // [R09]
                cmp_src[wdata_i[2:0]] <= wdata_i[9:8]; // [R08]
            end
            if (wr_hit(REG_CMP_ON)) begin
                cmp_on[cmp_index] <= wdata_i; // [R09]
            end
            if (wr_hit(REG_CMP_OFF)) begin
                cmp_off[cmp_index] <= wdata_i; // [R09]
            end
        end
    end

    // hardware enable select; the unusable bit is never stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hardware_enable_select <= HWEN_RST;
        end else if (wr_hit(REG_HWEN)) begin
            hardware_enable_select <= wdata_i[HWEN_W-1:0] &
                ~(13'(1) << HWEN_UNUSABLE); // [R10]
        end
    end

    // software drive commands and latched fault
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_drive_en <= 1'b0;
            fault_latched <= 1'b0;
        end else begin
            if (wr_hit(REG_DRIVE) && wdata_i[DRV_DIS]) begin
                sw_drive_en <= 1'b0; // [R11]
            end else if (wr_hit(REG_DRIVE) && wdata_i[DRV_EN]) begin
                sw_drive_en <= 1'b1; // [R11]
            end
            // a fault present in the clear cycle stays latched
            if (flt_s2) begin
                fault_latched <= 1'b1;
            end else if (wr_hit(REG_DRIVE) && wdata_i[DRV_CLRF]) begin
                fault_latched <= 1'b0; // [R12]
            end
        end
    end

    // drive enable: any selected input high, else software control
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_enable_o <= 1'b0;
            drive_fault_o <= 1'b0;
        end else begin
            drive_fault_o <= fault_latched;
            if (hardware_enable_select == '0) begin
                drive_enable_o <= sw_drive_en & ~fault_latched; // [R11]
            end else begin
                drive_enable_o <= ~fault_latched &
                    |(hardware_enable_select &
                    {din_s2, 1'b0, loc_s2}); // [R10]
            end
        end
    end

    // interrupt status: set wins over the clear in the same cycle
    assign irq_evt = {flt_s2 & ~fault_latched, do_reti, take_irq};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
            irq_en <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_hit(REG_IRQ_CLR)) begin
                irq_stat <= (irq_stat & ~wdata_i[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat <= irq_stat | irq_evt;
            end
            if (wr_hit(REG_IRQ_EN)) begin
                irq_en <= wdata_i[IRQ_W-1:0];
            end
            irq_o <= |(irq_stat & irq_en);
        end
    end

    // read port; data valid the cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                REG_STATUS: rdata_o <= event_source_status; // [R01]
                REG_CTRL: rdata_o <= {30'h0, global_en, 1'b0};
                REG_ACTIVE: rdata_o <= {27'h0,
                    active_source_number_o}; // [R06]
                REG_HWEN: rdata_o <= {19'h0, hardware_enable_select};
                REG_DRIVE: rdata_o <= {29'h0, fault_latched,
                    1'b0, sw_drive_en};
                REG_IRQ_STAT: rdata_o <= {29'h0, irq_stat};
                REG_IRQ_EN: rdata_o <= {29'h0, irq_en};
                REG_CMP_SEL: rdata_o <= {22'h0, cmp_src[cmp_index],
                    5'h0, cmp_index};
                REG_CMP_ON: rdata_o <= cmp_on[cmp_index];
                REG_CMP_OFF: rdata_o <= cmp_off[cmp_index];
                REG_VECTOR: rdata_o <= {16'h0,
                    vector_line[active_source_number_o]};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end
endmodule // motion_event_interrupt_unit

/* File: dv/meiu_chk.sv */
// port checker for the motion event interrupt unit
`timescale 1ns/100ps
module meiu_chk
    import meiu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic handler_done_i,
    input wire logic interrupt_req_o,
    input wire logic [LINE_W-1:0] handler_line_o,
    input wire logic [4:0] active_source_number_o,
    input wire logic drive_enable_o,
    input wire logic drive_fault_o
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic ret_w;
    // a handler return comes by pin or by register write
    assign ret_w = handler_done_i | (wr_i && addr_i == REG_RETURN);
    chk_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    chk_status_rsv: assert property (
        rd_i && addr_i == REG_STATUS |=> rdata_o[21:20] == 2'h0)
        else $error("reserved event bits not zero");
    chk_service_hold: assert property (
        interrupt_req_o && !ret_w |=> interrupt_req_o)
        else $error("service ended without return");
    chk_fields_stable: assert property (
        interrupt_req_o && $past(interrupt_req_o)
        |-> $stable(active_source_number_o) && $stable(handler_line_o))
        else $error("source number or line moved in service");
    chk_return_drop: assert property (
        interrupt_req_o && ret_w |=> !interrupt_req_o)
        else $error("request stayed after return");
    chk_hwen_bit8: assert property (
        rd_i && addr_i == REG_HWEN
        |=> rdata_o[8] == 1'b0 && rdata_o[31:13] == 19'h0)
        else $error("select bit 8 or upper bits read back set");
    chk_fault_off: assert property (
        drive_fault_o && $past(drive_fault_o) |-> !drive_enable_o)
        else $error("drive enabled while fault latched");
    chk_active_read: assert property (
        rd_i && addr_i == REG_ACTIVE
        |=> rdata_o == {27'h0, $past(active_source_number_o)})
        else $error("active number read differs from port");
    chk_vector_read: assert property (
        rd_i && addr_i == REG_VECTOR
        |=> rdata_o == {16'h0, $past(handler_line_o)})
        else $error("vector read differs from port");
endmodule // meiu_chk

bind motion_event_interrupt_unit meiu_chk u_chk (.clk_i, .rst_n_i,
    .addr_i, .wr_i, .rd_i, .rdata_o, .handler_done_i, .interrupt_req_o,
    .handler_line_o, .active_source_number_o, .drive_enable_o,
    .drive_fault_o);

/* File: dv/motion_event_interrupt_unit_test.sv */
// self-checking bench for the motion event interrupt unit
`timescale 1ns/100ps
module motion_event_interrupt_unit_test
    import meiu_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i, wr_i, rd_i, timer_event_i, cam_index_i, bus_message_i;
    logic drive_fault_i, handler_done_i, interrupt_req_o, drive_enable_o;
    logic drive_fault_o, irq_o;
    logic [7:0] addr_i, local_inputs_i;
    logic [31:0] wdata_i, rdata_o;
    logic [4:0] motion_flags_i, active_source_number_o;
    logic [3:0] drive_status_word_i, drive_inputs_i;
    logic [1:0] input_capture_i;
    logic [POS_W-1:0] axis_feedback_position_i, master_position_i;
    logic [POS_W-1:0] cam_master_position_i;
    logic [LINE_W-1:0] handler_line_o;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    motion_event_interrupt_unit u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .local_inputs_i, .motion_flags_i,
        .drive_status_word_i, .timer_event_i, .cam_index_i, .bus_message_i,
        .input_capture_i, .drive_inputs_i, .drive_fault_i,
        .axis_feedback_position_i, .master_position_i,
        .cam_master_position_i, .handler_done_i, .interrupt_req_o,
        .handler_line_o, .active_source_number_o, .drive_enable_o,
        .drive_fault_o, .irq_o);

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    task automatic wrap_up;
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up;
        end
    end

    task automatic c(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // wait n edges, then step past them so outputs have settled
    task automatic at(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic r(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        c(rdata_o, exp);
    endtask
    task automatic ret_pin;
        @(posedge clk_i);
        handler_done_i <= 1'b1;
        @(posedge clk_i);
        handler_done_i <= 1'b0;
        at(2);
        c(interrupt_req_o, 32'h0);
    endtask

    task automatic t_status;
        @(posedge clk_i);
        local_inputs_i <= 8'hA5;
        motion_flags_i <= 5'h13;
        drive_status_word_i <= 4'h9;
        timer_event_i <= 1'b1;
        bus_message_i <= 1'b1;
        input_capture_i <= 2'h2;
        w(REG_STATUS, 32'hFFFFFFFF);
        at(4);
        r(REG_STATUS, {2'h2, 10'h0, 3'h5, 4'h9, 5'h13, 8'hA5});
        @(posedge clk_i);
        {local_inputs_i, motion_flags_i, drive_status_word_i} <= '0;
        {timer_event_i, bus_message_i, input_capture_i} <= '0;
        cam_index_i <= 1'b1;
        at(4);
        r(REG_STATUS, 32'h00040000);
    endtask

    // each comparator watches a source by index mod 3
    task automatic t_cmp;
        logic [7:0] m;
        for (int i = 0; i < NUM_CMP; i++) begin
            w(REG_CMP_SEL, (32'(i % 3) << 8) | 32'(i));
            w(REG_CMP_ON, 32'h200);
            w(REG_CMP_OFF, 32'h2FF);
        end
        r(REG_CMP_SEL, 32'h0107);
        r(REG_CMP_ON, 32'h200);
        r(REG_CMP_OFF, 32'h2FF);
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_i);
            axis_feedback_position_i <= (s == 0) ? 32'h2FF : 32'h100;
            master_position_i <= (s == 1) ? 32'h200 : 32'h300;
            cam_master_position_i <= (s == 2) ? 32'h250 : 32'h1FF;
            at(4);
            for (int i = 0; i < NUM_CMP; i++) m[i] = (i % 3 == s);
            r(REG_STATUS, {2'h0, m, 3'h0, 19'h40000});
        end
        @(posedge clk_i);
        cam_master_position_i <= 32'h100;
    endtask

    // every edge code against a rise and a fall on source 0
    task automatic t_edges;
        logic e;
        for (int k = 0; k < 4; k++) begin
            for (int d = 0; d < 2; d++) begin
                w(REG_SETUP, {16'(k + 1), 6'h0, 2'(k), 8'h0});
                w(REG_CTRL, 32'h2);
                @(posedge clk_i);
                local_inputs_i[0] <= (d == 0);
                at(6);
                e = (d == 0) ? k[0] : k[1];
                c(interrupt_req_o, 32'(e));
                if (e) begin
                    c(handler_line_o, 32'(k + 1));
                    ret_pin;
                end
            end
        end
    endtask

    task automatic t_prio;
        @(posedge clk_i);
        local_inputs_i <= 8'h20;
        w(REG_SETUP, {16'h1234, 6'h0, EDGE_RISE, 8'h03});
        w(REG_SETUP, {16'h0055, 6'h0, EDGE_FALL, 8'h05});
        at(4);
        @(posedge clk_i);
        local_inputs_i <= 8'h08;
        at(6);
        c({active_source_number_o, handler_line_o}, 32'h31234);
        r(REG_ACTIVE, 32'h3);
        r(REG_VECTOR, 32'h1234);
        r(REG_CTRL, 32'h0);
        c(irq_o, 32'h0);
        w(REG_IRQ_EN, 32'h1);
        at(3);
        c(irq_o, 32'h1);
        r(REG_IRQ_EN, 32'h1);
        w(REG_RETURN, 32'h0);
        at(2);
        c(interrupt_req_o, 32'h0);
        r(REG_CTRL, 32'h2);
        // source 3 is now disarmed and the source 5 edge was lost
        @(posedge clk_i);
        local_inputs_i <= 8'h00;
        at(6);
        @(posedge clk_i);
        local_inputs_i <= 8'h08;
        at(6);
        c(interrupt_req_o, 32'h0);
        w(REG_IRQ_CLR, 32'h7);
        at(3);
        c(irq_o, 32'h0);
        w(REG_SETUP, {16'h0777, 6'h0, EDGE_BOTH, 8'h03});
        w(REG_CTRL, 32'h3);
        r(REG_CTRL, 32'h0);
        @(posedge clk_i);
        local_inputs_i <= 8'h00;
        at(6);
        c(interrupt_req_o, 32'h0);
        w(REG_CTRL, 32'h2);
        @(posedge clk_i);
        local_inputs_i <= 8'h08;
        at(6);
        c({interrupt_req_o, handler_line_o}, 32'h10777);
        ret_pin;
    endtask

    task automatic t_drive;
        w(REG_IRQ_CLR, 32'h7);
        w(REG_DRIVE, 32'h1);
        at(2);
        c(drive_enable_o, 32'h1);
        w(REG_DRIVE, 32'h3);
        at(2);
        c(drive_enable_o, 32'h0);
        w(REG_HWEN, 32'h1FFF);
        r(REG_HWEN, 32'h1EFF);
        w(REG_HWEN, 32'h0200);
        @(posedge clk_i);
        drive_inputs_i <= 4'h1;
        at(4);
        c(drive_enable_o, 32'h1);
        @(posedge clk_i);
        drive_inputs_i <= 4'hE;
        at(4);
        c(drive_enable_o, 32'h0);
        w(REG_DRIVE, 32'h1);
        w(REG_HWEN, 32'h0);
        @(posedge clk_i);
        drive_fault_i <= 1'b1;
        at(4);
        @(posedge clk_i);
        drive_fault_i <= 1'b0;
        at(4);
        c({drive_fault_o, drive_enable_o}, 32'h2);
        r(REG_DRIVE, 32'h5);
        r(REG_IRQ_STAT, 32'h4);
        w(REG_DRIVE, 32'h4);
        at(3);
        c({drive_fault_o, drive_enable_o}, 32'h1);
    endtask

    // reset, then the scenarios in turn
    initial begin
        rst_n_i = 1'b0;
        {addr_i, wdata_i, wr_i, rd_i, handler_done_i} = '0;
        {local_inputs_i, motion_flags_i, drive_status_word_i} = '0;
        {timer_event_i, cam_index_i, bus_message_i, input_capture_i} = '0;
        {drive_inputs_i, drive_fault_i} = '0;
        axis_feedback_position_i = 32'h100;
        master_position_i = 32'h100;
        cam_master_position_i = 32'h100;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        at(1);
        c({interrupt_req_o, drive_enable_o}, 32'h0);
        c({drive_fault_o, irq_o}, 32'h0);
        r(REG_HWEN, 32'h0);
        r(8'hF0, 32'h0);
        t_status;
        t_cmp;
        t_edges;
        t_prio;
        t_drive;
        wrap_up;
    end
endmodule // motion_event_interrupt_unit_test
